// file: verilog/tpp_cfg.svh
/*
  Offsets, field positions and reset values for the timer2/PWM/prescaler block.
  Assumes inclusion by bare name from package and module files.
*/
`ifndef TPP_CFG_SVH
`define TPP_CFG_SVH

// register indices; byte address is four times the index
`define TPP_IDX_COUNT      6'h09
`define TPP_IDX_CTRL_ONE   6'h0A
`define TPP_IDX_CTRL_TWO   6'h0B
`define TPP_IDX_DUTY_LOW   6'h0C
`define TPP_IDX_PRESCALE   6'h0D
`define TPP_IDX_HIGH_BITS  6'h10
`define TPP_IDX_IRQ_STATUS 6'h11
`define TPP_IDX_IRQ_CLEAR  6'h12
`define TPP_IDX_IRQ_ENABLE 6'h13

// shared high-byte field positions
`define TPP_HI_RELOAD_MSB  7
`define TPP_HI_RELOAD_LSB  6
`define TPP_HI_DUTY_MSB    3
`define TPP_HI_DUTY_LSB    2

// reset values
`define TPP_RST_CTRL_ONE   8'h00
`define TPP_RST_CTRL_TWO   8'h3F
`define TPP_RST_PRESCALE   8'hFF
`define TPP_RST_COUNT      10'h000
`define TPP_RST_BYTE       8'h00

// counter limits
`define TPP_COUNT_TOP      10'h3FF
`define TPP_COUNT_ZERO     10'h000
`define TPP_RATE_TOP       3'h7

// interrupt status bit positions
`define TPP_IRQ_UNDERFLOW  0
`define TPP_IRQ_ONESHOT    1

`endif

// file: verilog/tpp_pkg.sv
/*
  Types shared by the timer2/PWM/prescaler design files.
  Assumes tpp_cfg.svh is on the include path.
*/
`include "tpp_cfg.svh"

package tpp_pkg;

  typedef struct packed {
    logic       pwm_output_enable;
    logic       pwm_polarity_bit;
    logic [1:0] unused;
    logic       shared_hosc_select;
    logic       one_shot_bit;
    logic       reload_select_bit;
    logic       timer_enable_bit;
  } tpp_ctrl_one_type;

  typedef struct packed {
    logic [1:0] unused;
    logic       clock_source_select;
    logic       ext_edge_select;
    logic       prescaler_disable_n;
    logic [2:0] prescaler_rate_select;
  } tpp_ctrl_two_type;

  typedef logic [1:0] tpp_irq_type;

endpackage : tpp_pkg

// file: verilog/tpp_prescaler.sv
/*
  Prescaler: 8-bit down counter dividing a tick stream by 2 to 256.
  Assumes tick_in is a one-cycle enable pulse in the clk domain.
*/
`timescale 1ns/1ps
`include "tpp_cfg.svh"

module tpp_prescaler (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       tick_in,
  input  wire logic       disable_n,
  input  wire logic [2:0] rate_select,
  output logic            tick_out,
  output logic [7:0]      count
);
  import tpp_pkg::*;

  function automatic logic [7:0] rate_mask(input logic [2:0] sel);
    rate_mask = 8'hFF >> (`TPP_RATE_TOP - sel);
  endfunction : rate_mask

  ////////////////////////////////////////////////////////////////////////////
  // counter state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= `TPP_RST_PRESCALE;
    end else if (tick_in && !disable_n) begin
      count <= count - 8'h01;
    end
  end

  // ratio from rate select
  // bypass when disabled so the timer still sees every source tick
  assign tick_out = disable_n ? tick_in
                  : (tick_in && ((count & rate_mask(rate_select)) == 8'h00));

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  presc_bypass_a: assert property (disable_n |-> (tick_out == tick_in))
    else $error("prescaler bypass does not pass ticks");
  presc_div2_a: assert property (
    (tick_out && !disable_n && rate_select == 3'h0) |-> count[0] == 1'b0)
    else $error("prescaler 1:2 tick at wrong phase");

endmodule : tpp_prescaler

// file: verilog/tpp_top.sv
/*
  Timer2 with PWM channel and prescaler, reached over Avalon-MM.
  Summary of operation list below; assumes tick inputs are one-cycle clk
  enables and the external clock pin is synchronous to clk.
*/
//
// Summary of operation
// - reading count register returns low byte of the 10-bit counter
// - writing count loads counter with written byte and shared high bits [7:6]
// - counter decrements only while enable bit is set
// - free-run, reload clear: underflow continues from 0x3FF
// - free-run, reload set: underflow reloads the 10-bit reload value
// - one-shot: count to zero, ignore reload select, stop at underflow
// - shared high-oscillator bit clocks both timers from high oscillator
// - with shared bit clear each timer follows its own source select
// - source select clear: instruction clock; set: external pin
// - edge select 1 counts falling edges, 0 counts rising edges
// - active-low prescaler enable; rate 000 is 1:2 up to 111 is 1:256
// - polarity 1 makes PWM active low, 0 active high
// - PWM enable drives pins B2 and B5, else they stay GPIO
// - period from reload value when reload select is set, duty from high bits [3:2] and duty byte
// - reading prescaler count register returns prescaler counter
`timescale 1ns/1ps
`include "tpp_cfg.svh"

module tpp_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        instr_tick,
  input  wire logic        hosc_tick,
  input  wire logic        ext_clock_pin,
  input  wire logic        gpio_b2_out,
  input  wire logic        gpio_b2_oe,
  input  wire logic        gpio_b5_out,
  input  wire logic        gpio_b5_oe,
  output logic             port_b_bit_two_out,
  output logic             port_b_bit_two_oe,
  output logic             port_b_bit_five_out,
  output logic             port_b_bit_five_oe,
  output logic             shared_hosc_select,
  output logic             pwm_channel,
  output tpp_pkg::tpp_irq_type irq_status_out,
  output logic             irq
);
  import tpp_pkg::*;

  tpp_ctrl_one_type timer_ctrl_one;
  tpp_ctrl_two_type timer_ctrl_two;
  logic [7:0]       reload_byte;
  logic [7:0]       pwm_duty_reg;
  logic [1:0]       reload_high;
  logic [1:0]       duty_high;
  logic [9:0]       count;
  logic             stopped;
  tpp_irq_type      irq_status;
  tpp_irq_type      irq_enable;
  tpp_irq_type      events;
  logic             ack;
  logic [5:0]       idx;
  logic             wr_en;
  logic [7:0]       wd;
  logic [7:0]       rd_mux;
  logic             ext_prev;
  logic             ext_edge;
  logic             src_tick;
  logic             presc_tick;
  logic [7:0]       prescaler_count_reg;
  logic             tick_eff;
  logic             underflow;
  logic [9:0]       reload_value;
  logic [9:0]       duty_value;
  logic             pwm_level;
  logic             wr_count;
  logic             wr_ctrl_one;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] i);
    hit = (a == i);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle per access, then accept
  assign idx         = address[7:2];
  assign wd          = writedata[7:0];
  assign waitrequest = (read || write) && !ack;
  assign wr_en       = write && ack && byteenable[0];
  assign wr_count    = wr_en && hit(idx, `TPP_IDX_COUNT);
  assign wr_ctrl_one = wr_en && hit(idx, `TPP_IDX_CTRL_ONE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
    end else if (ack) begin
      ack <= 1'b0;
    end else begin
      ack <= read || write;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      `TPP_IDX_COUNT:      rd_mux = count[7:0];
      `TPP_IDX_CTRL_ONE:   rd_mux = timer_ctrl_one;
      `TPP_IDX_CTRL_TWO:   rd_mux = timer_ctrl_two;
      `TPP_IDX_PRESCALE:   rd_mux = prescaler_count_reg;
      `TPP_IDX_HIGH_BITS:  rd_mux = {reload_high, 2'b00, duty_high, 2'b00};
      `TPP_IDX_IRQ_STATUS: rd_mux = {6'h00, irq_status};
      `TPP_IDX_IRQ_ENABLE: rd_mux = {6'h00, irq_enable};
      default:             rd_mux = 8'h00;
    endcase
  end

  // sampled in the wait cycle, so it stands at the accepting edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h00000000;
    end else if (read && !ack) begin
      readdata <= {24'h000000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_ctrl_one <= `TPP_RST_CTRL_ONE;
    end else if (wr_ctrl_one) begin
      timer_ctrl_one        <= wd;
      timer_ctrl_one.unused <= 2'b00;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_ctrl_two <= `TPP_RST_CTRL_TWO;
    end else if (wr_en && hit(idx, `TPP_IDX_CTRL_TWO)) begin
      timer_ctrl_two        <= wd;
      timer_ctrl_two.unused <= 2'b00;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reload_byte <= `TPP_RST_BYTE;
    end else if (wr_count) begin
      reload_byte <= wd;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_duty_reg <= `TPP_RST_BYTE;
    end else if (wr_en && hit(idx, `TPP_IDX_DUTY_LOW)) begin
      pwm_duty_reg <= wd;
    end
  end

  // only the bits this timer owns are kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reload_high <= 2'b00;
      duty_high   <= 2'b00;
    end else if (wr_en && hit(idx, `TPP_IDX_HIGH_BITS)) begin
      reload_high <= wd[`TPP_HI_RELOAD_MSB:`TPP_HI_RELOAD_LSB];
      duty_high   <= wd[`TPP_HI_DUTY_MSB:`TPP_HI_DUTY_LSB];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_enable <= 2'b00;
    end else if (wr_en && hit(idx, `TPP_IDX_IRQ_ENABLE)) begin
      irq_enable <= wd[1:0];
    end
  end

  assign reload_value = {reload_high, reload_byte};
  // duty from high bits and duty byte
  assign duty_value   = {duty_high, pwm_duty_reg};

  ////////////////////////////////////////////////////////////////////////////
  // clock source selection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_clock_pin;
    end
  end

  assign ext_edge = timer_ctrl_two.ext_edge_select ? (ext_prev && !ext_clock_pin)
                                                   : (!ext_prev && ext_clock_pin);

  assign src_tick = timer_ctrl_one.shared_hosc_select ? hosc_tick
                  : (timer_ctrl_two.clock_source_select ? ext_edge : instr_tick);

  assign shared_hosc_select = timer_ctrl_one.shared_hosc_select;

  tpp_prescaler u_prescaler (
    .clk         (clk),
    .nrst        (nrst),
    .tick_in     (src_tick),
    .disable_n   (timer_ctrl_two.prescaler_disable_n),
    .rate_select (timer_ctrl_two.prescaler_rate_select),
    .tick_out    (presc_tick),
    .count       (prescaler_count_reg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // down counter
  // count only while enabled
  assign tick_eff  = timer_ctrl_one.timer_enable_bit && !stopped && presc_tick;
  assign underflow = tick_eff && (count == `TPP_COUNT_ZERO);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= `TPP_RST_COUNT;
    end else if (wr_count) begin
      count <= {reload_high, wd};
    end else if (underflow) begin
      if (timer_ctrl_one.one_shot_bit) begin
        count <= `TPP_COUNT_ZERO;
      end else if (timer_ctrl_one.reload_select_bit) begin
        count <= reload_value;
      end else begin
        count <= `TPP_COUNT_TOP;
      end
    end else if (tick_eff) begin
      count <= count - 10'h001;
    end
  end

  // a new count or timer_ctrl_one write rearms a finished one-shot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stopped <= 1'b0;
    end else if (wr_count || wr_ctrl_one) begin
      stopped <= 1'b0;
    end else if (underflow && timer_ctrl_one.one_shot_bit) begin
      stopped <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over a clear in the same cycle
  assign events[`TPP_IRQ_UNDERFLOW] = underflow;
  assign events[`TPP_IRQ_ONESHOT]   = underflow && timer_ctrl_one.one_shot_bit;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= 2'b00;
    end else if (wr_en && hit(idx, `TPP_IDX_IRQ_CLEAR)) begin
      irq_status <= (irq_status & ~wd[1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  assign irq            = |(irq_status & irq_enable);
  assign irq_status_out = irq_status;

  ////////////////////////////////////////////////////////////////////////////
  // PWM output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_level <= 1'b0;
    end else begin
      pwm_level <= (count < duty_value) ^ timer_ctrl_one.pwm_polarity_bit;
    end
  end

  assign pwm_channel = pwm_level;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_b_bit_two_out  <= 1'b0;
      port_b_bit_two_oe   <= 1'b0;
      port_b_bit_five_out <= 1'b0;
      port_b_bit_five_oe  <= 1'b0;
    end else if (timer_ctrl_one.pwm_output_enable) begin
      port_b_bit_two_out  <= (count < duty_value) ^ timer_ctrl_one.pwm_polarity_bit;
      port_b_bit_two_oe   <= 1'b1;
      port_b_bit_five_out <= (count < duty_value) ^ timer_ctrl_one.pwm_polarity_bit;
      port_b_bit_five_oe  <= 1'b1;
    end else begin
      port_b_bit_two_out  <= gpio_b2_out;
      port_b_bit_two_oe   <= gpio_b2_oe;
      port_b_bit_five_out <= gpio_b5_out;
      port_b_bit_five_oe  <= gpio_b5_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence rd_count_wait_s;
    read && !ack && hit(idx, `TPP_IDX_COUNT);
  endsequence

  sequence rd_accept_s;
    read && ack;
  endsequence

  read_count_a: assert property (rd_count_wait_s ##1 rd_accept_s
      |-> readdata[7:0] == $past(count[7:0]))
    else $error("count readback differs from counter");
  read_presc_a: assert property ((read && !ack && hit(idx, `TPP_IDX_PRESCALE)) ##1
      rd_accept_s |-> readdata[7:0] == $past(prescaler_count_reg))
    else $error("prescaler readback differs from counter");
  count_load_a: assert property (wr_count |=> count == reload_value)
    else $error("count write did not load reload value");
  hold_disabled_a: assert property (
      (!timer_ctrl_one.timer_enable_bit && !wr_count) |=> $stable(count))
    else $error("counter moved while disabled");
  wrap_top_a: assert property ((underflow && !wr_count && !timer_ctrl_one.one_shot_bit
      && !timer_ctrl_one.reload_select_bit) |=> count == `TPP_COUNT_TOP)
    else $error("free-run underflow did not wrap to top");
  wrap_reload_a: assert property ((underflow && !wr_count && !timer_ctrl_one.one_shot_bit
      && timer_ctrl_one.reload_select_bit) |=> count == $past(reload_value))
    else $error("free-run underflow did not reload");
  oneshot_stop_a: assert property ((underflow && !wr_count && !wr_ctrl_one
      && timer_ctrl_one.one_shot_bit) |=> (count == `TPP_COUNT_ZERO && stopped)
      ##1 ($past(wr_count) || count == `TPP_COUNT_ZERO))
    else $error("one-shot did not stop at zero");
  hosc_source_a: assert property (timer_ctrl_one.shared_hosc_select
      |-> src_tick == hosc_tick)
    else $error("high oscillator not selected");
  ext_edge_a: assert property ((!timer_ctrl_one.shared_hosc_select
      && timer_ctrl_two.clock_source_select && timer_ctrl_two.ext_edge_select
      && $fell(ext_clock_pin)) |-> src_tick)
    else $error("falling edge on pin not counted");
  instr_source_a: assert property ((!timer_ctrl_one.shared_hosc_select
      && !timer_ctrl_two.clock_source_select) |-> src_tick == instr_tick)
    else $error("instruction clock not selected");
  pwm_level_a: assert property (1'b1 |=> pwm_channel ==
      (($past(count) < $past(duty_value)) ^ $past(timer_ctrl_one.pwm_polarity_bit)))
    else $error("pwm level wrong for count and duty");
  pin_drive_a: assert property (timer_ctrl_one.pwm_output_enable ##1
      timer_ctrl_one.pwm_output_enable |-> port_b_bit_two_oe && port_b_bit_five_oe
      && port_b_bit_two_out == pwm_channel && port_b_bit_five_out == pwm_channel)
    else $error("pwm not on port pins");
  sticky_under_a: assert property (underflow |=> irq_status[`TPP_IRQ_UNDERFLOW])
    else $error("underflow flag not set");
  wait_bound_a: assert property ((read || write) |-> ##[0:1] !waitrequest)
    else $error("bus access not answered in one wait cycle");

endmodule : tpp_top

// file: tb/tb_top.sv
/*
  Self-checking bench for the timer2/PWM/prescaler block.
  Assumes tpp_pkg and tpp_top are compiled first; the bench drives every port itself.
*/
`timescale 1ns/1ps
`include "tpp_cfg.svh"

module tb_top;
  import tpp_pkg::*;

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        instr_tick = 1'b0;
  logic        hosc_tick = 1'b0;
  logic        ext_clock_pin = 1'b0;
  logic        gpio_b2_out = 1'b0;
  logic        gpio_b5_out = 1'b0;
  logic        pin2_out, pin2_oe, pin5_out, pin5_oe, hosc_sel, pwm, irq;
  tpp_irq_type irq_status;
  int          failures = 0;
  int          check_count = 0;
  logic [7:0]  q, c, p;
  int          n;

  always #12.5 clk = ~clk;

  tpp_top dut (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .instr_tick(instr_tick), .hosc_tick(hosc_tick),
    .ext_clock_pin(ext_clock_pin), .gpio_b2_out(gpio_b2_out), .gpio_b2_oe(1'b1),
    .gpio_b5_out(gpio_b5_out), .gpio_b5_oe(1'b0), .port_b_bit_two_out(pin2_out),
    .port_b_bit_two_oe(pin2_oe), .port_b_bit_five_out(pin5_out),
    .port_b_bit_five_oe(pin5_oe), .shared_hosc_select(hosc_sel), .pwm_channel(pwm),
    .irq_status_out(irq_status), .irq(irq));

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h0, got}, {7'h0, exp}, what);
  endtask : chk1

  // a search loop that ran out of its bound ends the run as a mismatch
  task automatic limit(input int used);
    if (used >= 600) begin
      failures++;
      $display("CHECK FAILED %0t wait limit reached", $time);
      stop_test();
    end
  endtask : limit

  // one Avalon access; request held until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be);
    int k;
    k = 0;
    address    <= a;
    writedata  <= {24'h0, d};
    byteenable <= be;
    read       <= ~wr;
    write      <= wr;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    q = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    if (k >= 20) begin
      failures++;
      $display("CHECK FAILED %0t bus timeout", $time);
      stop_test();
    end
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    xfer(1'b0, a, 8'h00, 4'hF);
    chk8(q, exp, what);
  endtask : rd

  // single source tick, then time for count, status and pins to settle
  task automatic pulse(input logic hosc);
    if (hosc) hosc_tick <= 1'b1;
    else instr_tick <= 1'b1;
    @(posedge clk);
    hosc_tick  <= 1'b0;
    instr_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic pin(input logic v);
    ext_clock_pin <= v;
    repeat (4) @(posedge clk);
  endtask : pin

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(8'h28, 8'h00, "ctrl_one reset");
    rd(8'h2C, 8'h3F, "ctrl_two reset");
    rd(8'h34, 8'hFF, "prescaler reset");
    rd(8'h3C, 8'h00, "unmapped read");
    wr(8'h28, 8'h01);
    xfer(1'b1, 8'h28, 8'h07, 4'hE);
    rd(8'h28, 8'h01, "byteenable off");
    done("reset");

    wr(8'h2C, 8'h08);
    wr(8'h40, 8'h80);
    wr(8'h24, 8'h05);
    repeat (3) pulse(1'b0);
    rd(8'h24, 8'h02, "count low byte");
    wr(8'h28, 8'h00);
    repeat (2) pulse(1'b0);
    rd(8'h24, 8'h02, "hold when disabled");
    rd(8'h30, 8'h00, "duty reads zero");
    done("load");

    wr(8'h40, 8'h00);
    wr(8'h28, 8'h01);
    wr(8'h24, 8'h02);
    repeat (3) pulse(1'b0);
    rd(8'h24, 8'hFF, "wrap to top");
    rd(8'h44, 8'h01, "underflow status");
    chk8({6'h00, irq_status}, 8'h01, "status output");
    chk1(irq, 1'b0, "irq masked");
    wr(8'h4C, 8'h03);
    chk1(irq, 1'b1, "irq raised");
    wr(8'h48, 8'h03);
    rd(8'h44, 8'h00, "status cleared");
    chk1(irq, 1'b0, "irq cleared");
    wr(8'h28, 8'h03);
    wr(8'h24, 8'h03);
    repeat (4) pulse(1'b0);
    rd(8'h24, 8'h03, "reload value");
    wr(8'h28, 8'h07);
    wr(8'h24, 8'h02);
    repeat (5) pulse(1'b0);
    rd(8'h24, 8'h00, "one-shot stop");
    rd(8'h44, 8'h03, "one-shot status");
    chk8({6'h00, irq_status}, 8'h03, "one-shot output");
    wr(8'h48, 8'h03);
    done("modes");

    wr(8'h28, 8'h01);
    for (int s = 0; s < 8; s++) begin
      wr(8'h2C, 8'h08 | 8'(s));
      wr(8'h2C, 8'(s));
      xfer(1'b0, 8'h34, 8'h00, 4'hF);
      p = q;
      pulse(1'b0);
      rd(8'h34, p - 8'h01, "prescaler count");
      xfer(1'b0, 8'h24, 8'h00, 4'hF);
      c = q;
      n = 0;
      while (q === c && n < 600) begin
        pulse(1'b0);
        xfer(1'b0, 8'h24, 8'h00, 4'hF);
        n++;
      end
      limit(n);
      c = q;
      n = 0;
      while (q === c && n < 600) begin
        pulse(1'b0);
        xfer(1'b0, 8'h24, 8'h00, 4'hF);
        n++;
      end
      limit(n);
      chk8(8'(n - 1), 8'((2 << s) - 1), "division ratio");
      // disable before the next rate change
      wr(8'h2C, 8'h08 | 8'(s));
    end
    done("prescaler");

    wr(8'h2C, 8'h38);
    xfer(1'b0, 8'h24, 8'h00, 4'hF);
    c = q;
    pin(1'b1);
    rd(8'h24, c, "rise ignored");
    pin(1'b0);
    rd(8'h24, c - 8'h01, "falling edge");
    wr(8'h2C, 8'h28);
    pin(1'b1);
    rd(8'h24, c - 8'h02, "rising edge");
    pulse(1'b0);
    rd(8'h24, c - 8'h02, "instr ignored");
    // prescaler disabled under the high oscillator
    wr(8'h2C, 8'h08);
    wr(8'h28, 8'h09);
    chk1(hosc_sel, 1'b1, "shared select out");
    pulse(1'b0);
    rd(8'h24, c - 8'h02, "instr masked");
    pulse(1'b1);
    rd(8'h24, c - 8'h03, "hosc tick");
    wr(8'h28, 8'h01);
    pulse(1'b1);
    pulse(1'b0);
    rd(8'h24, c - 8'h04, "own source");
    done("clocks");

    wr(8'h28, 8'h83);
    wr(8'h30, 8'h02);
    wr(8'h24, 8'h04);
    repeat (2) @(posedge clk);
    chk1(pwm, 1'b0, "pwm inactive");
    chk1(pin2_oe, 1'b1, "pin two driven");
    pulse(1'b0);
    pulse(1'b0);
    pulse(1'b0);
    chk1(pwm, 1'b1, "pwm active");
    chk1(pin2_out, 1'b1, "pin two pwm");
    chk1(pin5_out, 1'b1, "pin five pwm");
    wr(8'h28, 8'hC3);
    repeat (2) @(posedge clk);
    chk1(pwm, 1'b0, "active low");
    wr(8'h40, 8'h04);
    wr(8'h28, 8'h83);
    wr(8'h24, 8'hFF);
    repeat (2) @(posedge clk);
    chk1(pwm, 1'b1, "duty high bits");
    wr(8'h28, 8'h03);
    repeat (2) @(posedge clk);
    chk1(pin2_out, 1'b0, "gpio two");
    chk1(pin5_out, 1'b0, "gpio five");
    chk1(pin5_oe, 1'b0, "gpio five oe");
    done("pwm");
    stop_test();
  end

endmodule : tb_top
